// >>> src/wdg_pkg.sv
// Constants, register map and state encoding shared by the watchdog design files.
package wdg_pkg;

  // Reference clock rate in MHz; the watchdog oscillator runs at this rate.
  localparam int CLK_MHZ = 10;

  // The printed control register offset is not word aligned, so it is kept as an index.
  localparam logic [7:0] REG_CTRL_INDEX = 8'h2A;
  localparam logic [7:0] REG_CFG_INDEX = 8'h2B;
  localparam logic [7:0] REG_STAT_INDEX = 8'h2C;
  localparam int ADDR_W = 12;

  // Control register layout and reset value.
  localparam logic [7:0] CTRL_RESET = 8'h7F;
  localparam int CTRL_ACT_BIT = 7;
  localparam int CTRL_TOP_BIT = 6;
  localparam logic [6:0] COUNT_EXPIRE = 7'h40;

  // Configuration register layout: time base select and real-time-clock interrupt enable.
  localparam int CFG_RTC_IE_BIT = 0;
  localparam int CFG_TB_LO = 1;
  localparam logic [2:0] CFG_RESET = 3'h0;

  // Status register layout.
  localparam int STAT_ACTIVE_BIT = 6;
  localparam int STAT_HWOPT_BIT = 7;

  // Prescaler: 64 oscillator cycles per unit, 256 units per decrement (16384 cycles).
  localparam logic [5:0] UNIT_LAST = 6'h3F;
  localparam logic [7:0] STAGE_LAST = 8'hFF;
  localparam logic [8:0] STAGE_SPAN = 9'h100;
  localparam logic [8:0] MIN_UNITS = 9'h080;
  localparam logic [7:0] MIN_STAGE_BASE = 8'h80;

  // Start-up delays in CPU clock cycles.
  localparam logic [12:0] STARTUP_SHORT = 13'h0100;
  localparam logic [12:0] STARTUP_LONG = 13'h1000;

  // Reset pulse width on the reset pin.
  localparam int RESET_PULSE_US = 30;
  localparam logic [8:0] RESET_PULSE_CYC = 9'(RESET_PULSE_US * CLK_MHZ);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    ST_BOOT = 6'h01,
    ST_RUN = 6'h02,
    ST_HALT_LAST = 6'h04,
    ST_HALT = 6'h08,
    ST_AHALT = 6'h10,
    ST_WAKE = 6'h20
  } wdg_state_t;

  // Offset of the first permitted decrement after a refresh, per time base.
  function automatic logic [6:0] tb_lsb(input logic [1:0] tb);
    case (tb)
      2'h0: tb_lsb = 7'h3B;
      2'h1: tb_lsb = 7'h35;
      2'h2: tb_lsb = 7'h23;
      default: tb_lsb = 7'h36;
    endcase
  endfunction : tb_lsb

  // Byte address match for a register index.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] index);
    reg_hit = (addr == {2'h0, index, 2'h0});
  endfunction : reg_hit

endpackage : wdg_pkg

// >>> src/wdg_prescaler.sv
// Prescaler producing the watchdog decrement tick every 16384 oscillator cycles.
`timescale 1ns/1ns
`default_nettype none
module wdg_prescaler (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [6:0] lsb_i,
  output logic tick_o
);
  import wdg_pkg::*;

  logic [5:0] unit_cnt;
  logic [5:0] next_unit_cnt;
  logic [7:0] stage;
  logic [7:0] next_stage;
  logic next_tick;

  // The divide-by-64 part is shared with the time base and is never disturbed by a refresh.
  always_comb begin
    next_unit_cnt = unit_cnt + 6'h01;
    next_stage = stage;
    if (unit_cnt == UNIT_LAST) begin
      next_stage = stage + 8'h01;
    end
    // A refresh too close to the next tick pushes it out; one spare unit covers the part
    // of the current unit already gone, so the minimum holds at any prescaler phase.
    if (load_i && ((STAGE_SPAN - {1'b0, stage}) <= ({2'h0, lsb_i} + MIN_UNITS))) begin
      next_stage = MIN_STAGE_BASE - {1'b0, lsb_i} - 8'h01;
    end
    // A tick due in the refresh cycle is dropped, because the stage was just pushed out.
    next_tick = (unit_cnt == UNIT_LAST) && (stage == STAGE_LAST) && !load_i;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      unit_cnt <= 6'h00;
      stage <= 8'h00;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      unit_cnt <= next_unit_cnt;
      stage <= next_stage;
      tick_o <= next_tick;
    end
  end

endmodule : wdg_prescaler
`default_nettype wire

// >>> src/wdg_start_timer.sv
// Start-up delay counter of 256 or 4096 CPU clocks.
`timescale 1ns/1ns
`default_nettype none
module wdg_start_timer (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic long_i,
  output logic done_o
);
  import wdg_pkg::*;

  logic [12:0] remain;
  logic [12:0] next_remain;

  always_comb begin
    next_remain = remain;
    if (load_i) begin
      next_remain = long_i ? STARTUP_LONG : STARTUP_SHORT;
    end else if (remain != 13'h0000) begin
      next_remain = remain - 13'h0001;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      remain <= 13'h0000;
    end else if (ce_i) begin
      remain <= next_remain;
    end
  end

  assign done_o = (remain == 13'h0000);

endmodule : wdg_start_timer
`default_nettype wire

// >>> src/windowed_reset_watchdog.sv
// Watchdog downcounter with halt handling and an AXI4-Lite register slave.
//
// Overview of operation
// - Decrement count every 16384 oscillator cycles.
// - Active and 40h to 3Fh: 30 us reset.
// - Count runs while inactive; reset needs activation; here the Halt option reset fires even while inactive.
// - Low six bits give 64 timeout steps.
// - Inactive after reset; activation cannot be cleared.
// - Write with activation, bit 6 clear: reset.
// - First decrement (LSB+128)*64 to 16384 cycles later.
// - Halt, no interrupt, no option: enter Halt.
// - Halt: one more decrement, then freeze, no reset.
// - External wake from Halt: resume after start-up delay.
// - Reset in Halt leaves watchdog inactive unless hardware.
// - Halt, no interrupt, option set: reset instead.
// - Halt with interrupt enabled enters Active-halt.
// - Active-halt holds the count.
// - Interrupt wake from Active-halt resumes at once.
// - Reset wake resumes after start-up delay.
// - Hardware option keeps watchdog always active.
// - Control: activation bit 7, count 6..0, reset 7Fh.
// - Software sets activation; only reset clears it.
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module windowed_reset_watchdog (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [wdg_pkg::ADDR_W-1:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [wdg_pkg::ADDR_W-1:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  input wire logic halt_req_i,
  input wire logic ext_wake_i,
  input wire logic osc_wake_i,
  input wire logic hw_watchdog_opt_i,
  input wire logic halt_reset_option_i,
  input wire logic long_startup_opt_i,
  output logic mcu_reset_b_o,
  output logic watchdog_active_o
);
  import wdg_pkg::*;

  // Option levels come from outside the clock domain and are synchronised per bit.
  // The synchronisers have no reset, so the options have settled when reset is released;
  // the start-up delay chosen in the boot cycle depends on them.
  logic [2:0] opt_raw;
  logic [2:0] opt_meta;
  logic [2:0] opt_sync;
  assign opt_raw = {long_startup_opt_i, halt_reset_option_i, hw_watchdog_opt_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_opt_sync
      always_ff @(posedge ref_clk_i) begin
        if (ce_i) begin
          opt_meta[gi] <= opt_raw[gi];
          opt_sync[gi] <= opt_meta[gi];
        end
      end
    end
  endgenerate

  logic hw_opt;
  logic halt_reset_option;
  logic long_startup;
  assign hw_opt = opt_sync[0];
  assign halt_reset_option = opt_sync[1];
  assign long_startup = opt_sync[2];

  // Bus state.
  logic aw_full;
  logic next_aw_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [ADDR_W-1:0] next_aw_addr;
  logic w_full;
  logic next_w_full;
  logic [7:0] w_data;
  logic [7:0] next_w_data;
  logic w_lane0;
  logic next_w_lane0;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic wr_go;
  logic wr_ctrl;
  logic wr_cfg;

  // Watchdog state.
  logic activation_flag;
  logic next_activation_flag;
  logic [6:0] timeout_setting;
  logic [6:0] next_timeout_setting;
  logic rtc_interrupt_enable;
  logic next_rtc_interrupt_enable;
  logic [1:0] timebase_select;
  logic [1:0] next_timebase_select;
  wdg_state_t state;
  wdg_state_t next_state;
  logic [8:0] pulse_cnt;
  logic [8:0] next_pulse_cnt;
  logic next_reset_b;
  logic next_active;
  logic eff_active;
  logic counting;
  logic fire;
  logic timer_load;
  logic timer_done;
  logic tick;

  assign wr_go = aw_full && w_full && !bvalid_o;
  assign wr_ctrl = wr_go && w_lane0 && reg_hit(aw_addr, REG_CTRL_INDEX);
  assign wr_cfg = wr_go && w_lane0 && reg_hit(aw_addr, REG_CFG_INDEX);
  assign eff_active = activation_flag || hw_opt;

  // Address and data are taken in either order; the response waits for both.
  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid_o;
    next_bresp = bresp_o;
    next_rvalid = rvalid_o;
    next_rdata = rdata_o;
    next_rresp = rresp_o;
    if (awvalid_i && awready_o) begin
      next_aw_full = 1'b1;
      next_aw_addr = awaddr_i;
    end
    if (wvalid_i && wready_o) begin
      next_w_full = 1'b1;
      next_w_data = wdata_i[7:0];
      next_w_lane0 = wstrb_i[0];
    end
    if (bvalid_o && bready_i) begin
      next_bvalid = 1'b0;
    end
    if (wr_go) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_SLVERR;
      if (reg_hit(aw_addr, REG_CTRL_INDEX) || reg_hit(aw_addr, REG_CFG_INDEX)
          || reg_hit(aw_addr, REG_STAT_INDEX)) begin
        next_bresp = RESP_OKAY;
      end
    end
    if (rvalid_o && rready_i) begin
      next_rvalid = 1'b0;
    end
    if (arvalid_i && arready_o) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (reg_hit(araddr_i, REG_CTRL_INDEX)) begin
        next_rdata[7:0] = {activation_flag, timeout_setting};
      end else if (reg_hit(araddr_i, REG_CFG_INDEX)) begin
        next_rdata[CFG_TB_LO+1:CFG_RTC_IE_BIT] = {timebase_select, rtc_interrupt_enable};
      end else if (reg_hit(araddr_i, REG_STAT_INDEX)) begin
        next_rdata[5:0] = state;
        next_rdata[STAT_ACTIVE_BIT] = eff_active;
        next_rdata[STAT_HWOPT_BIT] = hw_opt;
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end
    next_awready = !next_aw_full;
    next_wready = !next_w_full;
    next_arready = !next_rvalid;
  end

  // Counting, halt modes and reset generation.
  always_comb begin
    next_state = state;
    next_activation_flag = activation_flag;
    next_timeout_setting = timeout_setting;
    next_rtc_interrupt_enable = rtc_interrupt_enable;
    next_timebase_select = timebase_select;
    next_pulse_cnt = pulse_cnt;
    fire = 1'b0;
    timer_load = 1'b0;
    counting = (state == ST_RUN) || (state == ST_HALT_LAST);
    if (wr_cfg) begin
      next_rtc_interrupt_enable = w_data[CFG_RTC_IE_BIT];
      next_timebase_select = w_data[CFG_TB_LO+1:CFG_TB_LO];
    end
    if (wr_ctrl) begin
      // Activation can only be set here; reset is the sole way back to zero.
      next_activation_flag = activation_flag || w_data[CTRL_ACT_BIT];
      next_timeout_setting = w_data[CTRL_TOP_BIT:0];
      if ((w_data[CTRL_ACT_BIT] || hw_opt) && !w_data[CTRL_TOP_BIT]) begin
        fire = 1'b1;
      end
    end else if (tick && counting) begin
      // The counter wraps freely whether or not the watchdog is active.
      next_timeout_setting = timeout_setting - 7'h01;
      if (state == ST_RUN && eff_active && timeout_setting == COUNT_EXPIRE) begin
        fire = 1'b1;
      end
    end
    case (state)
      ST_BOOT: begin
        timer_load = 1'b1;
        next_state = ST_WAKE;
      end
      ST_RUN: begin
        if (halt_req_i) begin
          if (rtc_interrupt_enable) begin
            next_state = ST_AHALT;
          end else if (halt_reset_option) begin
            fire = 1'b1;
          end else begin
            next_state = ST_HALT_LAST;
          end
        end
      end
      ST_HALT_LAST: begin
        if (ext_wake_i) begin
          timer_load = 1'b1;
          next_state = ST_WAKE;
        end else if (tick) begin
          next_state = ST_HALT;
        end
      end
      ST_HALT: begin
        if (ext_wake_i) begin
          timer_load = 1'b1;
          next_state = ST_WAKE;
        end
      end
      ST_AHALT: begin
        // The count is held here because counting is false in this state.
        if (osc_wake_i || ext_wake_i) begin
          next_state = ST_RUN;
        end
      end
      ST_WAKE: begin
        if (timer_done) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_BOOT;
      end
    endcase
    // A new reset request while the pin is already low does not stretch the pulse.
    if (fire && pulse_cnt == 9'h000) begin
      next_pulse_cnt = RESET_PULSE_CYC;
    end else if (pulse_cnt != 9'h000) begin
      next_pulse_cnt = pulse_cnt - 9'h001;
    end
    next_reset_b = (next_pulse_cnt == 9'h000);
    next_active = next_activation_flag || hw_opt;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
      w_full <= 1'b0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      awready_o <= 1'b0;
      wready_o <= 1'b0;
      bvalid_o <= 1'b0;
      bresp_o <= RESP_OKAY;
      arready_o <= 1'b0;
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      rresp_o <= RESP_OKAY;
    end else if (ce_i) begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      awready_o <= next_awready;
      wready_o <= next_wready;
      bvalid_o <= next_bvalid;
      bresp_o <= next_bresp;
      arready_o <= next_arready;
      rvalid_o <= next_rvalid;
      rdata_o <= next_rdata;
      rresp_o <= next_rresp;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      activation_flag <= 1'b0;
      timeout_setting <= CTRL_RESET[CTRL_TOP_BIT:0];
      rtc_interrupt_enable <= CFG_RESET[CFG_RTC_IE_BIT];
      timebase_select <= CFG_RESET[CFG_TB_LO+1:CFG_TB_LO];
      state <= ST_BOOT;
      pulse_cnt <= 9'h000;
      mcu_reset_b_o <= 1'b1;
      watchdog_active_o <= 1'b0;
    end else if (ce_i) begin
      activation_flag <= next_activation_flag;
      timeout_setting <= next_timeout_setting;
      rtc_interrupt_enable <= next_rtc_interrupt_enable;
      timebase_select <= next_timebase_select;
      state <= next_state;
      pulse_cnt <= next_pulse_cnt;
      mcu_reset_b_o <= next_reset_b;
      watchdog_active_o <= next_active;
    end
  end

  wdg_prescaler u_prescaler (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .load_i(wr_ctrl),
    .lsb_i(tb_lsb(timebase_select)),
    .tick_o(tick)
  );

  wdg_start_timer u_start_timer (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .load_i(timer_load),
    .long_i(long_startup),
    .done_o(timer_done)
  );

endmodule : windowed_reset_watchdog
`default_nettype wire

// >>> dv/wdg_checker_properties.sv
// Checker for the watchdog register bus and the reset pin pulse.
`timescale 1ns/1ns
`default_nettype none
module wdg_checker (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic awvalid_i,
  input wire logic awready_o,
  input wire logic wvalid_i,
  input wire logic wready_o,
  input wire logic bvalid_o,
  input wire logic [1:0] bresp_o,
  input wire logic arvalid_i,
  input wire logic arready_o,
  input wire logic rvalid_o,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0] rresp_o,
  input wire logic mcu_reset_b_o,
  input wire logic watchdog_active_o
);
  import wdg_pkg::*;
  logic [9:0] low_cnt;
  logic [9:0] next_low_cnt;
  always_comb begin
    next_low_cnt = mcu_reset_b_o ? 10'h000 : low_cnt + 10'h001;
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_cnt <= 10'h000;
    end else begin
      low_cnt <= next_low_cnt;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  pulse_width_a: assert property ($rose(mcu_reset_b_o) |-> low_cnt == {1'b0, RESET_PULSE_CYC})
    else $error("reset pulse not 300 cycles");
  pulse_cap_a: assert property (low_cnt <= {1'b0, RESET_PULSE_CYC})
    else $error("reset pulse too long");
  pulse_low_a: assert property ($fell(mcu_reset_b_o) |=> !mcu_reset_b_o [*8])
    else $error("reset pulse cut short");
  write_resp_a: assert property (awvalid_i && awready_o && wvalid_i && wready_o
    |=> !awready_o && !wready_o ##1 bvalid_o)
    else $error("write answer late");
  read_resp_a: assert property (arvalid_i && arready_o |=> rvalid_o && !arready_o)
    else $error("read answer late");
  read_block_a: assert property (rvalid_o |-> !arready_o)
    else $error("read taken while answer pending");
  slverr_data_a: assert property (rvalid_o && rresp_o == RESP_SLVERR |-> rdata_o == 32'h0)
    else $error("error read carries data");
  resp_code_a: assert property (bvalid_o |-> bresp_o == RESP_OKAY || bresp_o == RESP_SLVERR)
    else $error("bad write response");
  active_keep_a: assert property (watchdog_active_o |=> watchdog_active_o)
    else $error("activation lost without reset");
endmodule : wdg_checker
bind windowed_reset_watchdog wdg_checker i_wdg_checker (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
  .wvalid_i(wvalid_i), .wready_o(wready_o), .bvalid_o(bvalid_o), .bresp_o(bresp_o),
  .arvalid_i(arvalid_i), .arready_o(arready_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o),
  .rresp_o(rresp_o), .mcu_reset_b_o(mcu_reset_b_o), .watchdog_active_o(watchdog_active_o)
);
`default_nettype wire

// >>> dv/test_windowed_reset_watchdog.sv
// Self-checking testbench for the windowed reset watchdog.
`timescale 1ns/1ns
`default_nettype none
module test_windowed_reset_watchdog;
  import wdg_pkg::*;
  localparam logic [11:0] CTRL_A = {2'h0, REG_CTRL_INDEX, 2'h0};
  localparam logic [11:0] CFG_A = {2'h0, REG_CFG_INDEX, 2'h0};
  localparam logic [11:0] STAT_A = {2'h0, REG_STAT_INDEX, 2'h0};
  logic ref_clk_i = 1'b0, rst_b_i = 1'b0, awvalid_i = 1'b0, wvalid_i = 1'b0;
  logic bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0, halt_req_i = 1'b0;
  logic ext_wake_i = 1'b0, osc_wake_i = 1'b0, hw_i = 1'b0, hro_i = 1'b0, long_i = 1'b0;
  logic [11:0] awaddr_i = 12'h000, araddr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0, rdata_o, d;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, mcu_reset_b_o, active_o, seen;
  logic [1:0] bresp_o, rresp_o, r;
  int num_errors = 0, cmp_count = 0, cyc;
  windowed_reset_watchdog i_windowed_reset_watchdog (.ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i), .ce_i(1'b1), .awvalid_i(awvalid_i), .awready_o(awready_o),
    .awaddr_i(awaddr_i), .wvalid_i(wvalid_i), .wready_o(wready_o), .wdata_i(wdata_i),
    .wstrb_i(4'h1), .bvalid_o(bvalid_o), .bready_i(bready_i), .bresp_o(bresp_o),
    .arvalid_i(arvalid_i), .arready_o(arready_o), .araddr_i(araddr_i), .rvalid_o(rvalid_o),
    .rready_i(rready_i), .rdata_o(rdata_o), .rresp_o(rresp_o), .halt_req_i(halt_req_i),
    .ext_wake_i(ext_wake_i), .osc_wake_i(osc_wake_i), .hw_watchdog_opt_i(hw_i),
    .halt_reset_option_i(hro_i), .long_startup_opt_i(long_i), .mcu_reset_b_o(mcu_reset_b_o),
    .watchdog_active_o(active_o));
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    int n;
    n = 0;
    awaddr_i <= a;
    wdata_i <= {24'h0, v};
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (awready_o === 1'b1) awvalid_i <= 1'b0;
      if (wready_o === 1'b1) wvalid_i <= 1'b0;
    end while (bvalid_o !== 1'b1 && n < 50);
    bready_i <= 1'b0;
    r = bresp_o;
    if (n >= 50) begin
      check("write answer", 32'h1, 32'h0);
      test_done();
    end
    // One idle edge keeps this release and the next request in separate time steps.
    @(posedge ref_clk_i);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (arready_o === 1'b1) arvalid_i <= 1'b0;
    end while (rvalid_o !== 1'b1 && n < 50);
    rready_i <= 1'b0;
    d = rdata_o;
    r = rresp_o;
    if (n >= 50) begin
      check("read answer", 32'h1, 32'h0);
      test_done();
    end
    @(posedge ref_clk_i);
  endtask : rd
  // Options are only changed while reset is held, as a real option byte would be.
  task automatic do_reset(input logic hw, input logic hro);
    rst_b_i <= 1'b0;
    hw_i <= hw;
    hro_i <= hro;
    repeat (6) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (300) @(posedge ref_clk_i);
  endtask : do_reset
  task automatic wait_low(input int maxc);
    cyc = 0;
    seen = 1'b0;
    while (!seen && cyc < maxc) begin
      @(posedge ref_clk_i);
      cyc++;
      seen = (mcu_reset_b_o === 1'b0);
    end
  endtask : wait_low
  task automatic pulse_halt();
    halt_req_i <= 1'b1;
    @(posedge ref_clk_i);
    halt_req_i <= 1'b0;
  endtask : pulse_halt
  task automatic t_regs();
    rd(CTRL_A);
    check("ctrl reset value", 32'h7F, d);
    check("active after reset", 32'h0, {31'h0, active_o});
    rd(12'hFFC);
    check("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(CTRL_A, 8'h00);
    wait_low(40);
    check("reset while inactive", 32'h0, {31'h0, seen});
    wr(CTRL_A, 8'hFF);
    check("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
    wr(CTRL_A, 8'h7F);
    rd(CTRL_A);
    check("activation kept", 32'h1, {31'h0, d[7]});
    check("active output", 32'h1, {31'h0, active_o});
    wr(CTRL_A, 8'h80);
    wait_low(5);
    check("software reset", 32'h1, {31'h0, seen});
    do_reset(1'b0, 1'b0);
    rd(CTRL_A);
    check("ctrl after reset", 32'h7F, d);
    $display("register test done");
  endtask : t_regs
  task automatic t_timeout();
    wr(CTRL_A, 8'hC1);
    wait_low(40000);
    check("timeout reset", 32'h1, {31'h0, seen});
    check("timeout window", 32'h1, {31'h0, cyc >= 28350 && cyc <= 32771});
    do_reset(1'b0, 1'b1);
    $display("timeout test done");
  endtask : t_timeout
  task automatic t_halt_modes();
    pulse_halt();
    wait_low(10);
    check("halt reset option", 32'h1, {31'h0, seen});
    do_reset(1'b0, 1'b1);
    wr(CFG_A, 8'h07);
    rd(CFG_A);
    check("config readback", 32'h07, d);
    wr(CTRL_A, 8'hC0);
    pulse_halt();
    rd(STAT_A);
    check("active halt entry", 32'h10, {26'h0, d[5:0]});
    wait_low(16500);
    check("active halt no reset", 32'h0, {31'h0, seen});
    osc_wake_i <= 1'b1;
    @(posedge ref_clk_i);
    osc_wake_i <= 1'b0;
    rd(STAT_A);
    check("active halt wake", 32'h02, {26'h0, d[5:0]});
    rd(CTRL_A);
    check("active halt count held", 32'hC0, d);
    do_reset(1'b0, 1'b0);
    $display("halt option and active halt test done");
  endtask : t_halt_modes
  task automatic t_halt();
    wr(CTRL_A, 8'hC0);
    pulse_halt();
    rd(STAT_A);
    check("halt entry", 32'h04, {26'h0, d[5:0]});
    wait_low(16500);
    check("halt no reset", 32'h0, {31'h0, seen});
    rd(STAT_A);
    check("halt frozen", 32'h08, {26'h0, d[5:0]});
    rd(CTRL_A);
    check("halt last decrement", 32'hBF, d);
    ext_wake_i <= 1'b1;
    @(posedge ref_clk_i);
    ext_wake_i <= 1'b0;
    rd(STAT_A);
    check("wake delay", 32'h20, {26'h0, d[5:0]});
    repeat (262) @(posedge ref_clk_i);
    rd(STAT_A);
    check("wake resume", 32'h02, {26'h0, d[5:0]});
    $display("halt test done");
  endtask : t_halt
  task automatic t_hw();
    long_i <= 1'b1;
    do_reset(1'b1, 1'b0);
    check("hardware active", 32'h1, {31'h0, active_o});
    rd(STAT_A);
    check("long start-up", 32'hE0, {24'h0, d[7:0]});
    repeat (4000) @(posedge ref_clk_i);
    rd(STAT_A);
    check("long start-up end", 32'h02, {26'h0, d[5:0]});
    wr(CTRL_A, 8'h3F);
    wait_low(5);
    check("hardware soft reset", 32'h1, {31'h0, seen});
    wr(CTRL_A, 8'hC0);
    pulse_halt();
    rd(STAT_A);
    check("halt before reset", 32'h04, {26'h0, d[5:0]});
    long_i <= 1'b0;
    do_reset(1'b0, 1'b0);
    check("inactive after reset", 32'h0, {31'h0, active_o});
    $display("hardware option test done");
  endtask : t_hw
  initial begin
    do_reset(1'b0, 1'b0);
    t_regs();
    t_timeout();
    t_halt_modes();
    t_halt();
    t_hw();
    test_done();
  end
endmodule : test_windowed_reset_watchdog
`default_nettype wire
